/* rtl/pwr_defs.svh */
`ifndef PWR_DEFS_SVH
`define PWR_DEFS_SVH

// Register offsets on the plain register port
`define PWR_OFS_MODE      4'h0
`define PWR_OFS_CTRL      4'h1
`define PWR_OFS_WMASK     4'h2
`define PWR_OFS_CLKSEL    4'h3
`define PWR_OFS_STATE     4'h4

// Power mode register fields
`define PWR_CD_LO         0
`define PWR_CD_HI         1
`define PWR_SWB_BIT       2
// Power control register fields
`define PWR_IDLE_BIT      0
`define PWR_STOP_BIT      1
`define PWR_SLEEP_BIT     2
// Clock select register fields
`define PWR_CSEL_LO       0
`define PWR_CSEL_HI       1
`define PWR_WDLY_LO       5
`define PWR_WDLY_HI       7

// Reset values
`define PWR_MODE_RST      8'h01
`define PWR_CTRL_RST      8'h00
`define PWR_WMASK_RST     8'hFF
`define PWR_CLKSEL_RST    8'hC0

// Divider codes and counts
`define PWR_CD_DIVIDED    2'b11
`define PWR_CD_NORMAL     2'b01
`define PWR_DIV_RATIO     257
`define PWR_DLY_BASE      128
`define PWR_CSEL_INTERNAL_OSCILLATOR     2'b00

`endif

/* rtl/pwr_pkg.sv */
package pwr_pkg;
    typedef enum logic [3:0] {
        ST_RUN   = 4'b0001,
        ST_IDLE  = 4'b0010,
        ST_STOP  = 4'b0100,
        ST_WAKE  = 4'b1000
    } pwr_state_t;
    typedef logic [7:0] byte_t;
endpackage : pwr_pkg

/* rtl/pwr_sync.sv */
`timescale 1ns/10ps
`default_nettype none
module pwr_sync #(
    parameter int W = 8
) (
    // Clock and reset
    input  wire logic         clk,
    input  wire logic         sys_rst,
    // Data
    input  wire logic [W-1:0] async_in,
    output logic      [W-1:0] sync_out
);
    logic [W-1:0] meta_ff;

    // Two stage synchroniser; first stage feeds only the second
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            meta_ff  <= '0;
            sync_out <= '0;
        end else begin
            meta_ff  <= async_in;
            sync_out <= meta_ff;
        end
    end
endmodule : pwr_sync
`default_nettype wire

/* rtl/pwr_div.sv */
`timescale 1ns/10ps
`default_nettype none
module pwr_div #(
    parameter int RATIO = 257
) (
    // Clock and reset
    input  wire logic clk,
    input  wire logic sys_rst,
    // Control
    input  wire logic divide,
    output logic      tick
);
    localparam int CW = $clog2(RATIO);
    logic [CW-1:0] cnt_ff;

    // One pulse every RATIO cycles while dividing, every cycle otherwise
    always_ff @(posedge clk) begin
        if (sys_rst || !divide) begin
            cnt_ff <= '0;
        end else if (cnt_ff == CW'(RATIO - 1)) begin
            cnt_ff <= '0;
        end else begin
            cnt_ff <= cnt_ff + 1'b1;
        end
    end

    assign tick = !divide || (cnt_ff == CW'(RATIO - 1));
endmodule : pwr_div
`default_nettype wire

/* rtl/power_mode_controller.sv */
// Decided for this implementation: the register addresses and the address-and-strobe port.
`timescale 1ns/10ps
`default_nettype none
`include "pwr_defs.svh"

// Functional notes
// - Divider bits 11 run core and its peripherals at main clock over 257.
// - Outside peripherals stay on undivided main clock in divided mode.
// - Writing divider bits 01 returns to full speed.
// - Switchback enable lets interrupts, serial start bit or tx write exit.
// - Interrupt switchback needs enabled and not priority-blocked interrupt.
// - Receive switchback on start bit falling edge while receive enabled.
// - Transmit buffer write triggers switchback.
// - After switchback stay normal until software writes divider again.
// - Watchdog reset or reset pin forces exit from divided mode.
// - Idle bit gates core clocks; outside peripherals keep running.
// - Idle ends on reset pin, watchdog, or enabled interrupt line or peripheral flag.
// - Interrupt wake from idle restarts clock and vectors to handler.
// - Hardware clears idle bit on return to normal.
// - Stop bit halts all clocks except real-time clock.
// - Oscillator shuts off on its final edge, no partial pulse.
// - Stop exits only on reset pin, watchdog, interrupt lines, peripheral flags, comparator, RTC.
// - Pin and flag stop wake needs interrupt enable and wake mask bit; comparator and RTC need neither.
// - Pins wake on low level, peripheral flags on high level.
// - Wake restarts oscillator; CPU resumes once the wake delay count ends.
// - Stop wake clears stop bit and vectors to handler.
// - Stop plus sleep enters sleep, regulator off, on again at wake.
// - Eight wake mask bits permit each line; all reset to one.
// - Wake delay field selects 0 or 128 doubling to 8192 cycles.
// - Stop wake switches clock source selection to internal oscillator.
module power_mode_controller
    import pwr_pkg::*;
(
    // Clock and reset
    input  wire logic       clk,
    input  wire logic       sys_rst,
    // Reset sources
    input  wire logic       ext_reset_pin_n,
    input  wire logic       watchdog_reset,
    // Register port
    input  wire logic [3:0] reg_addr,
    input  wire logic [7:0] reg_wdata,
    input  wire logic       reg_wr,
    input  wire logic       reg_rd,
    output logic      [7:0] reg_rdata,
    // Interrupt side, same clock domain
    input  wire logic [7:0] int_enable,
    input  wire logic [7:0] int_not_blocked,
    input  wire logic [7:0] periph_int_flag,
    // Asynchronous wake sources
    input  wire logic [7:0] ext_interrupt_line_n,
    input  wire logic       serial_rx_pin,
    input  wire logic       comparator_wake,
    input  wire logic       rtc_wake,
    // Serial port zero, same clock domain
    input  wire logic       rx_enable,
    input  wire logic       tx_buffer_write,
    // Clock gating and power outputs
    output logic            core_clk_en,
    output logic            outer_clk_en,
    output logic            osc_enable,
    output logic            rtc_clk_en,
    output logic            regulator_on,
    output logic            int_vector_req,
    output logic      [7:0] wake_source
);
    import pwr_pkg::*;

    localparam int DLY_MAX = 8192;

    typedef struct packed {
        pwr_state_t state;
        logic [1:0] clock_divider_bits;
        logic       switchback_enable;
        logic       idle_bit;
        logic       stop_bit;
        logic       sleep_bit;
        byte_t      wake_mask;
        logic [2:0] wake_delay_field;
        logic [1:0] clock_source_select;
        logic [13:0] dly_cnt;
        logic       rx_prev;
        logic       vec;
        byte_t      wsrc;
        byte_t      rdata;
    } pmc_t;

    pmc_t cur_ff;
    pmc_t nxt_ff;

    logic [10:0] sync_in;
    logic [10:0] sync_out;
    logic [7:0]  line_low;
    logic        rx_s;
    logic        rst_pin;
    logic        async_wake;
    logic        div_tick;
    logic [7:0]  sb_int;
    logic [7:0]  stop_wake;
    logic        idle_wake;
    logic        switchback;

    // Pins and async sources resynchronised before use
    assign sync_in = {comparator_wake | rtc_wake, ~ext_reset_pin_n,
                      serial_rx_pin, ext_interrupt_line_n};

    pwr_sync #(.W(11)) u_sync (
        .clk      (clk),
        .sys_rst  (sys_rst),
        .async_in (sync_in),
        .sync_out (sync_out)
    );

    assign line_low   = ~sync_out[7:0];  // Active-low pins
    assign rx_s       = sync_out[8];
    assign rst_pin    = sync_out[9];
    assign async_wake = sync_out[10];

    // Divided enable for core side
    pwr_div #(.RATIO(`PWR_DIV_RATIO)) u_div (
        .clk     (clk),
        .sys_rst (sys_rst),
        .divide  (cur_ff.clock_divider_bits == `PWR_CD_DIVIDED),
        .tick    (div_tick)
    );

    // Interrupt request: pin low or peripheral flag high
    assign sb_int    = (line_low | periph_int_flag) & int_enable
                       & int_not_blocked;
    assign stop_wake = (line_low | periph_int_flag) & int_enable
                       & cur_ff.wake_mask;
    assign idle_wake = |((line_low | periph_int_flag) & int_enable);

    // Start bit falling edge, tx write, or interrupt
    assign switchback = cur_ff.switchback_enable &&
                        ((|sb_int) ||
                         (rx_enable && cur_ff.rx_prev && !rx_s) ||
                         tx_buffer_write);

    // Next state
    always_comb begin
        nxt_ff         = cur_ff;
        nxt_ff.rx_prev = rx_s;
        nxt_ff.vec     = 1'b0;
        nxt_ff.rdata   = 8'h00;

        // Register writes
        if (reg_wr) begin
            case (reg_addr)
                `PWR_OFS_MODE: begin
                    nxt_ff.clock_divider_bits =
                        reg_wdata[`PWR_CD_HI:`PWR_CD_LO];
                    nxt_ff.switchback_enable = reg_wdata[`PWR_SWB_BIT];
                end
                `PWR_OFS_CTRL: begin
                    nxt_ff.idle_bit  = reg_wdata[`PWR_IDLE_BIT];
                    nxt_ff.stop_bit  = reg_wdata[`PWR_STOP_BIT];
                    nxt_ff.sleep_bit = reg_wdata[`PWR_SLEEP_BIT];
                end
                `PWR_OFS_WMASK: begin
                    nxt_ff.wake_mask = reg_wdata;
                end
                `PWR_OFS_CLKSEL: begin
                    nxt_ff.wake_delay_field =
                        reg_wdata[`PWR_WDLY_HI:`PWR_WDLY_LO];
                    nxt_ff.clock_source_select =
                        reg_wdata[`PWR_CSEL_HI:`PWR_CSEL_LO];
                end
                default: begin
                end
            endcase
        end

        // Hardware switchback wins over a same-cycle divider write
        if (cur_ff.clock_divider_bits == `PWR_CD_DIVIDED && switchback) begin
            nxt_ff.clock_divider_bits = `PWR_CD_NORMAL;
        end

        // Mode sequencing
        case (cur_ff.state)
            ST_RUN: begin
                if (cur_ff.stop_bit) begin
                    nxt_ff.state = ST_STOP;
                end else if (cur_ff.idle_bit) begin
                    nxt_ff.state = ST_IDLE;
                end
            end
            ST_IDLE: begin
                if (idle_wake) begin
                    nxt_ff.state    = ST_RUN;
                    nxt_ff.idle_bit = 1'b0;
                    nxt_ff.vec      = 1'b1;
                    nxt_ff.wsrc     = (line_low | periph_int_flag)
                                      & int_enable;
                end
            end
            ST_STOP: begin
                if ((|stop_wake) || async_wake) begin
                    nxt_ff.state   = ST_WAKE;
                    nxt_ff.wsrc    = stop_wake;
                    nxt_ff.dly_cnt = (cur_ff.wake_delay_field == 3'd0) ?
                        14'd0 :
                        14'(`PWR_DLY_BASE <<
                            (cur_ff.wake_delay_field - 3'd1));
                end
            end
            ST_WAKE: begin
                if (cur_ff.dly_cnt == 14'd0) begin
                    nxt_ff.state     = ST_RUN;
                    nxt_ff.stop_bit  = 1'b0;
                    nxt_ff.sleep_bit = 1'b0;
                    nxt_ff.vec       = 1'b1;
                    nxt_ff.clock_source_select = `PWR_CSEL_INTERNAL_OSCILLATOR;
                end else begin
                    nxt_ff.dly_cnt = cur_ff.dly_cnt - 14'd1;
                end
            end
            default: begin
                nxt_ff.state = ST_RUN;
            end
        endcase

        // Reset pin or watchdog leave every low-power mode
        if (rst_pin || watchdog_reset) begin
            nxt_ff.state              = ST_RUN;
            nxt_ff.clock_divider_bits = `PWR_CD_NORMAL;
            nxt_ff.idle_bit           = 1'b0;
            nxt_ff.stop_bit           = 1'b0;
            nxt_ff.sleep_bit          = 1'b0;
        end

        // Read data, one cycle after the strobe
        if (reg_rd) begin
            case (reg_addr)
                `PWR_OFS_MODE:   nxt_ff.rdata = {5'd0,
                    cur_ff.switchback_enable, cur_ff.clock_divider_bits};
                `PWR_OFS_CTRL:   nxt_ff.rdata = {5'd0, cur_ff.sleep_bit,
                    cur_ff.stop_bit, cur_ff.idle_bit};
                `PWR_OFS_WMASK:  nxt_ff.rdata = cur_ff.wake_mask;
                `PWR_OFS_CLKSEL: nxt_ff.rdata = {cur_ff.wake_delay_field,
                    3'd0, cur_ff.clock_source_select};
                `PWR_OFS_STATE:  nxt_ff.rdata = {4'd0, cur_ff.state};
                default:         nxt_ff.rdata = 8'h00;
            endcase
        end
    end

    // State register
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            cur_ff <= '{state: ST_RUN,
                        clock_divider_bits: 2'(`PWR_MODE_RST),
                        switchback_enable: 1'b0,
                        idle_bit: 1'b0,
                        stop_bit: 1'b0,
                        sleep_bit: 1'b0,
                        wake_mask: `PWR_WMASK_RST,
                        wake_delay_field: 3'(`PWR_CLKSEL_RST >>
                                             `PWR_WDLY_LO),
                        clock_source_select: `PWR_CSEL_INTERNAL_OSCILLATOR,
                        dly_cnt: 14'd0,
                        rx_prev: 1'b1,
                        vec: 1'b0,
                        wsrc: 8'h00,
                        rdata: 8'h00};
        end else begin
            cur_ff <= nxt_ff;
        end
    end

    // Clock gating outputs; the oscillator enable is decoded from the registered state so it
    // drops on a clock edge and never chops a pulse
    assign core_clk_en    = (cur_ff.state == ST_RUN) && div_tick;
    assign outer_clk_en   = (cur_ff.state == ST_RUN) ||
                            (cur_ff.state == ST_IDLE);
    assign osc_enable     = (cur_ff.state != ST_STOP);
    assign rtc_clk_en     = 1'b1;
    assign regulator_on   = !((cur_ff.state == ST_STOP) &&
                              cur_ff.sleep_bit);
    assign int_vector_req = cur_ff.vec;
    assign wake_source    = cur_ff.wsrc;
    assign reg_rdata      = cur_ff.rdata;
endmodule : power_mode_controller
`default_nettype wire

/* testbench/pmc_monitor.sv */
`timescale 1ns/10ps
`default_nettype none
module pmc_monitor (
    // Clock, reset and reset sources
    input wire logic       clk,
    input wire logic       sys_rst,
    input wire logic       ext_reset_pin_n,
    input wire logic       watchdog_reset,
    // Register read side
    input wire logic       reg_rd,
    input wire logic [7:0] reg_rdata,
    // Clock and power outputs
    input wire logic       core_clk_en,
    input wire logic       outer_clk_en,
    input wire logic       osc_enable,
    input wire logic       rtc_clk_en,
    input wire logic       regulator_on,
    input wire logic       int_vector_req
);
    default clocking @(posedge clk); endclocking
    default disable iff (sys_rst);

    // Gating and power relations
    AST_RTC_ON: assert property (rtc_clk_en)
        else $error("rtc clock gated");
    AST_STOP_GATE: assert property (!osc_enable |-> !core_clk_en && !outer_clk_en)
        else $error("clock runs with oscillator off");
    AST_OSC_FALL: assert property ($fell(osc_enable) |-> $past(core_clk_en))
        else $error("oscillator cut outside a clean edge");
    AST_REG_OFF: assert property (!regulator_on |-> !osc_enable)
        else $error("regulator off outside stop");
    AST_REG_ON: assert property ($rose(regulator_on) |-> osc_enable)
        else $error("regulator back without oscillator");
    // Wake vector is a single pulse with the clock running
    AST_VEC_PULSE: assert property (int_vector_req |=> !int_vector_req)
        else $error("vector request longer than one cycle");
    AST_VEC_OSC: assert property (int_vector_req |-> osc_enable)
        else $error("vector request while oscillator off");
    // Reset sources leave full speed running; pin needs sync time
    AST_WDOG: assert property (watchdog_reset |=> osc_enable && core_clk_en)
        else $error("watchdog did not restore full speed");
    AST_RST_PIN: assert property (!ext_reset_pin_n [*5] |-> core_clk_en)
        else $error("reset pin did not restore full speed");
    AST_RD_QUIET: assert property (!$past(reg_rd) |-> reg_rdata == 8'h00)
        else $error("read data outside read slot");

    // Main scenarios
    cover property (int_vector_req);
    cover property (!regulator_on);
    cover property (!osc_enable ##1 osc_enable);
endmodule : pmc_monitor

bind power_mode_controller pmc_monitor mon (
    .clk(clk), .sys_rst(sys_rst), .ext_reset_pin_n(ext_reset_pin_n),
    .watchdog_reset(watchdog_reset), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .core_clk_en(core_clk_en),
    .outer_clk_en(outer_clk_en), .osc_enable(osc_enable),
    .rtc_clk_en(rtc_clk_en), .regulator_on(regulator_on),
    .int_vector_req(int_vector_req)
);
`default_nettype wire

/* testbench/wake_src_model.sv */
`timescale 1ns/10ps
`default_nettype none
module wake_src_model (
    // Requests from the bench
    input  wire logic [7:0] pull,
    input  wire logic       rx_start,
    // Pins toward the controller
    output logic      [7:0] line_n,
    output logic            rx_pin
);
    // Pulled-up lines, low only on request; skew keeps them off the edge
    assign #3 line_n = ~pull;
    // Start bit: one falling edge, then back to the idle high level
    initial rx_pin = 1'b1;
    always @(posedge rx_start) begin
        #7 rx_pin = 1'b0;
        #200 rx_pin = 1'b1;
    end
endmodule : wake_src_model
`default_nettype wire

/* testbench/tb.sv */
`timescale 1ns/10ps
`default_nettype none
module tb;
    logic       clk, sys_rst, pin_n, wdog, reg_wr, reg_rd, rx_en, tx_wr;
    logic       cmp_w, rtc_w, rx_start, rx_pin, core_en, outer_en;
    logic       osc_en, rtc_en, reg_on, vec;
    logic [3:0] reg_addr;
    logic [7:0] wdata, rdata, int_en, unblk, pull, line_n, bm, om, d8;
    logic [7:0] pflag, wsrc;
    int         fail_count, checks, cyc, mode_m, n, k, dly;

    // Device and far side
    power_mode_controller dut (.clk(clk), .sys_rst(sys_rst),
        .ext_reset_pin_n(pin_n), .watchdog_reset(wdog),
        .reg_addr(reg_addr), .reg_wdata(wdata), .reg_wr(reg_wr),
        .reg_rd(reg_rd), .reg_rdata(rdata), .int_enable(int_en),
        .int_not_blocked(unblk), .periph_int_flag(pflag),
        .ext_interrupt_line_n(line_n), .serial_rx_pin(rx_pin),
        .comparator_wake(cmp_w), .rtc_wake(rtc_w), .rx_enable(rx_en),
        .tx_buffer_write(tx_wr), .core_clk_en(core_en),
        .outer_clk_en(outer_en), .osc_enable(osc_en),
        .rtc_clk_en(rtc_en), .regulator_on(reg_on),
        .int_vector_req(vec), .wake_source(wsrc));
    wake_src_model far (.pull(pull), .rx_start(rx_start),
        .line_n(line_n), .rx_pin(rx_pin));

    initial clk = 1'b0;
    always #5 clk = ~clk;
    // Hang guard, well above the longest wake delay used
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            fail_count++;
            end_of_test();
        end
    end

    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        checks++;
        if (got !== exp) begin
            fail_count++;
            $display("mismatch t=%0t got %h exp %h", $time, got, exp);
        end
    endtask : chk
    task automatic wr(input logic [3:0] a, input logic [7:0] d);
        @(posedge clk);
        reg_addr <= a;
        wdata    <= d;
        reg_wr   <= 1'b1;
        @(posedge clk);
        reg_wr   <= 1'b0;
    endtask : wr
    task automatic rchk(input logic [3:0] a, input logic [7:0] e);
        @(posedge clk);
        reg_addr <= a;
        reg_rd   <= 1'b1;
        @(posedge clk);
        reg_rd   <= 1'b0;
        #1 chk(rdata, e);
    endtask : rchk
    // Count cycles until the wake vector pulse, bounded
    task automatic wait_vec(input int lim);
        n = 0;
        while (vec !== 1'b1 && n < lim) begin
            @(posedge clk);
            #1 n++;
        end
    endtask : wait_vec
    task automatic end_of_test();
        $display("checks %0d fail_count %0d", checks, fail_count);
        if (fail_count == 0 && checks > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask : end_of_test

    initial begin
        {sys_rst, pin_n} = 2'b11;
        {wdog, reg_wr, reg_rd, rx_en, tx_wr, cmp_w, rtc_w, rx_start} = '0;
        {reg_addr, wdata, int_en, unblk, pull, pflag} = '0;
        {fail_count, checks, cyc} = '0;
        void'($urandom(32'hb8aa));
        repeat (5) @(posedge clk);
        sys_rst <= 1'b0;
        k = $urandom_range(7, 0);
        bm = 8'h01 << k;
        om = 8'h01 << ((k + 1) % 8);
        mode_m = 1;
        // Reset values, unmapped place reads zero
        rchk(4'h0, 8'h01);
        rchk(4'h1, 8'h00);
        rchk(4'h2, 8'hFF);
        rchk(4'h3, 8'hC0);
        rchk(4'hF, 8'h00);
        // Divided speed: two core ticks in 514 cycles, outer always on
        wr(4'h0, 8'h03);
        {n, k} = '0;
        repeat (514) begin
            @(posedge clk);
            #1 n += int'(core_en === 1'b1);
            k += int'(outer_en === 1'b1);
        end
        chk(8'(n), 8'd2);
        chk(8'(k == 514), 8'h01);
        wr(4'h0, 8'h01);
        rchk(4'h0, 8'(mode_m));
        // Switchback causes: int, rx, tx, rx off, blocked int
        for (int c = 0; c < 5; c++) begin
            wr(4'h0, 8'h07);
            mode_m = (c < 3) ? 5 : 7;
            int_en   <= (c == 0 || c == 4) ? bm : 8'h00;
            unblk    <= (c == 0) ? 8'hFF : 8'h00;
            pull     <= (c == 0 || c == 4) ? bm : 8'h00;
            rx_en    <= (c == 1);
            rx_start <= (c == 1 || c == 3);
            tx_wr    <= (c == 2);
            @(posedge clk);
            {rx_start, tx_wr} <= 2'b00;
            repeat (8) @(posedge clk);
            pull <= 8'h00;
            rchk(4'h0, 8'(mode_m));
        end
        wr(4'h0, 8'h01);
        // Idle: core gated, outer running, interrupt wakes
        int_en <= bm;
        unblk  <= 8'hFF;
        wr(4'h1, 8'h01);
        repeat (3) @(posedge clk);
        #1 chk(8'(core_en), 8'h00);
        chk(8'(outer_en), 8'h01);
        pull <= bm;
        wait_vec(20);
        chk(8'(vec), 8'h01);
        pull <= 8'h00;
        rchk(4'h1, 8'h00);
        // Idle again, woken by a peripheral flag at high level
        wr(4'h1, 8'h01);
        repeat (3) @(posedge clk);
        pflag <= bm;
        wait_vec(20);
        chk(8'(vec), 8'h01);
        pflag <= 8'h00;
        chk(wsrc, bm);
        rchk(4'h1, 8'h00);
        // Stop: masked line ignored, unmasked line wakes after delay
        int_en <= 8'hFF;
        wr(4'h2, ~om);
        for (int d = 0; d < 4; d++) begin
            d8 = {3'(d), 5'b00001};
            wr(4'h3, d8);
            wr(4'h1, 8'h02);
            pull <= om;
            repeat (10) @(posedge clk);
            #1 chk(8'(osc_en), 8'h00);
            pull <= bm;
            wait_vec(9000);
            pull <= 8'h00;
            dly = (d == 0) ? 0 : 128 << (d - 1);
            chk(8'(vec), 8'h01);
            chk(8'(n >= dly && n <= dly + 8), 8'h01);
            chk(wsrc, bm);
            rchk(4'h1, 8'h00);
            rchk(4'h3, {3'(d), 5'b00000});
        end
        // Sleep: regulator off, comparator or rtc wake restores it
        wr(4'h1, 8'h06);
        repeat (3) @(posedge clk);
        #1 chk(8'(reg_on), 8'h00);
        k = $urandom_range(1, 0);
        {cmp_w, rtc_w} <= (k == 1) ? 2'b10 : 2'b01;
        wait_vec(9000);
        {cmp_w, rtc_w} <= 2'b00;
        chk(8'(reg_on), 8'h01);
        // Software keeps quiet for 20 us after a sleep wake
        repeat (2000) @(posedge clk);
        rchk(4'h1, 8'h00);
        // Watchdog and reset pin leave divided speed
        wr(4'h0, 8'h03);
        wdog <= 1'b1;
        @(posedge clk);
        wdog <= 1'b0;
        rchk(4'h0, 8'h01);
        wr(4'h0, 8'h03);
        pin_n <= 1'b0;
        repeat (6) @(posedge clk);
        pin_n <= 1'b1;
        repeat (4) @(posedge clk);
        rchk(4'h0, 8'h01);
        end_of_test();
    end
endmodule : tb
`default_nettype wire
